// file: rtl/srs_regs.svh
// Register offsets, reset values and timing counts for the reset sequencer.
`ifndef SRS_REGS_SVH
`define SRS_REGS_SVH
`define SRS_BLK_RST_ADDR      16'he63f
`define SRS_BLK_RST_RESET     8'h00
`define SRS_BLK_RST_MASK      8'h0e
`define SRS_BIT_TR            1
`define SRS_BIT_TDM           2
`define SRS_BIT_HDLC          3
`define SRS_PULSE_TU          8
`define SRS_PULSE_CYC         ((`SRS_PULSE_TU + 1) / 2)
`define SRS_SEQ_TU            2048
`define SRS_SEQ_CYC           11'd1024
`define SRS_HW_MIN_TU         16
`define SRS_HW_MIN_CYC        6'd8
`define SRS_WDOG_CYC          18'h20000
`define SRS_WDOG_RELOAD       8'h00
`define SRS_WCTRL_SWR_BIT     0
`define SRS_WCTRL_WDOG_RESET_FLAG_BIT    1
`define SRS_WCTRL_SHORT_HW_RESET_BIT    2
`define SRS_WCTRL_DIS_BIT     3
`endif

// file: rtl/srs_pkg.sv
// Types shared by the reset sequencer modules.
package srs_pkg;
  typedef enum logic [1:0] {
    SRS_SEQ_IDLE,
    SRS_SEQ_RUN,
    SRS_SEQ_HOLD,
    SRS_SEQ_LENGTHEN
  } srs_seq_t;
  typedef enum logic [1:0] {
    SRS_DSP_RESET,
    SRS_DSP_WAIT,
    SRS_DSP_ACTIVE
  } srs_dsp_t;
endpackage : srs_pkg

// file: rtl/srs_sync.sv
// Two-flop synchroniser for a pin level.
`timescale 1ns/100ps
module srs_sync (
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic stage1;
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      stage1 <= 1'b1;
      q_o    <= 1'b1;
    end
    else
    begin
      stage1 <= d_i;
      q_o    <= stage1;
    end
  end
endmodule : srs_sync

// file: rtl/srs_wdog.sv
// Watchdog counter with reload, service and disable.
`timescale 1ns/100ps
`include "srs_regs.svh"
module srs_wdog (
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  input  wire logic run_i,
  input  wire logic service_i,
  input  wire logic disable_i,
  output logic      overflow_o
);
  // Counting every CPU cycle stands for a half-rate clock with half the
  // count, so the overflow lands on the same cycle.
  logic [17:0] count;
  logic        off;
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || !run_i)
    begin
      count      <= 18'h00000;
      off        <= 1'b0;
      overflow_o <= 1'b0;
    end
    else
    begin
      overflow_o <= 1'b0;
      if (disable_i)
        off <= 1'b1;
      if (service_i)
        count <= {`SRS_WDOG_RELOAD, 10'h000};
      else if (!off && !disable_i)
      begin
        if (count == `SRS_WDOG_CYC - 18'h00001)
        begin
          overflow_o <= 1'b1;
          count      <= {`SRS_WDOG_RELOAD, 10'h000};
        end
        else
          count <= count + 18'h00001;
      end
    end
  end
endmodule : srs_wdog

// file: rtl/srs_sequencer.sv
// System reset sequencer: reset entry, sequence timing and reset outputs.
// Overview of operation
// - Soft reset instruction gives an 8-unit start pulse and marks soft type.
// - Internal reset stays active while the sequence runs; release starts code.
// - After a soft reset the startup configuration is latched again.
// - Watchdog overflow waits for bus cycle end, then sends 8-unit pulse.
// - Every reset lasts at least 2048 units, that is 1024 CPU cycles.
// - Every reset type starts the sequence; short ones are stretched.
// - Hardware reset is lengthened until oscillator and PLL are stable.
// - Idle wakeup does not lengthen reset; setup-active holds first fetch.
// - Lengthening does not stretch config sampling nor the pin reset.
// - No watchdog reset while in bootstrap loader mode.
// - Block reset register bits hold HDLC, TDM handler, transceiver reset.
// - Bus pins activate after the sequence; general I/O stays input.
// - System reset output goes low at the start of every sequence.
// - System reset output stays low until end-of-init executes.
// - Watchdog runs after reset, reload zero, overflows after 131072 cycles.
// - Watchdog reset sets its flag; hardware reset or service clears it.
// - Watchdog disable works only before first service or end-of-init.
// - DSP is held in reset while the system reset output is active.
// - DSP goes active on its first register access.
// - Reset pin low 16 units starts sequence; beyond 2048 is long reset.
`timescale 1ns/100ps
`include "srs_regs.svh"
module srs_sequencer (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic       ext_reset_in_n_i,
  input  wire logic       soft_reset_instr_i,
  input  wire logic       end_init_instr_i,
  input  wire logic       wdog_disable_instr_i,
  input  wire logic       wdog_service_instr_i,
  input  wire logic       ext_bus_busy_i,
  input  wire logic       bootstrap_mode_i,
  input  wire logic       osc_pll_stable_i,
  input  wire logic       idle_wakeup_i,
  input  wire logic       clk_dist_stable_i,
  input  wire logic [7:0] startup_cfg_i,
  input  wire logic       dsp_reg_access_i,
  input  wire logic [15:0] reg_addr_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  output logic            sys_reset_o,
  output logic            sys_reset_out_n_o,
  output logic            ext_reset_oe_o,
  output logic            ext_reset_out_o,
  output logic            setup_active_o,
  output logic            cfg_latch_o,
  output logic      [7:0] cfg_latched_o,
  output logic            bus_pins_active_o,
  output logic            gpio_output_en_o,
  output logic            hdlc_reset_o,
  output logic            tdm_reset_o,
  output logic            trx_reset_o,
  output logic            dsp_reset_o,
  output logic            dsp_active_o,
  output logic      [3:0] wdog_ctrl_reg_o,
  output logic            wdog_reset_flag_o
);
  import srs_pkg::*;

  srs_seq_t    seq_state;
  srs_dsp_t    dsp_state;
  logic        rst_pin_n;
  logic [5:0]  low_cnt;
  logic        hw_req;
  logic        long_hw;
  logic [10:0] seq_cnt;
  logic [2:0]  pulse_cnt;
  logic        pulse_soft;
  logic        pulse_wdog;
  logic        wdog_pend;
  logic        wdog_ovf;
  logic        wdog_run;
  logic        wdog_gate;
  logic        soft_type;
  logic        short_hw;
  logic        wdog_type;
  logic        dis_window;
  logic        wdog_off;
  logic [7:0]  blk_rst;
  logic        start_seq;
  logic        seq_done;

  function automatic logic addr_hit(input logic [15:0] a);
    addr_hit = (a == `SRS_BLK_RST_ADDR);
  endfunction : addr_hit

  srs_sync u_pin_sync (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .d_i       (ext_reset_in_n_i),
    .q_o       (rst_pin_n)
  );

  // The pin must stay low for the filter count before it counts as reset.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      low_cnt <= 6'd0;
      hw_req  <= 1'b0;
    end
    else if (rst_pin_n)
    begin
      low_cnt <= 6'd0;
      hw_req  <= 1'b0;
    end
    else
    begin
      if (low_cnt != `SRS_HW_MIN_CYC)
        low_cnt <= low_cnt + 6'd1;
      hw_req <= (low_cnt == `SRS_HW_MIN_CYC - 6'd1);
    end
  end

  // Start pulses last eight timing units, four CPU cycles.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      pulse_cnt  <= 3'd0;
      pulse_soft <= 1'b0;
      pulse_wdog <= 1'b0;
      wdog_pend  <= 1'b0;
    end
    else
    begin
      if (wdog_ovf && !bootstrap_mode_i)
        wdog_pend <= 1'b1;
      if (pulse_cnt != 3'd0)
      begin
        pulse_cnt <= pulse_cnt - 3'd1;
        if (pulse_cnt == 3'd1)
        begin
          pulse_soft <= 1'b0;
          pulse_wdog <= 1'b0;
        end
      end
      else if (seq_state == SRS_SEQ_IDLE && soft_reset_instr_i)
      begin
        pulse_soft <= 1'b1;
        pulse_cnt  <= 3'(`SRS_PULSE_CYC);
      end
      else if (seq_state == SRS_SEQ_IDLE && wdog_pend && !ext_bus_busy_i)
      begin
        pulse_wdog <= 1'b1;
        wdog_pend  <= 1'b0;
        pulse_cnt  <= 3'(`SRS_PULSE_CYC);
      end
    end
  end

  assign start_seq = hw_req || (pulse_cnt == 3'(`SRS_PULSE_CYC) &&
                     (pulse_soft || pulse_wdog));
  assign seq_done  = (seq_cnt == `SRS_SEQ_CYC - 11'd1);

  // Sequence: run 1024 cycles, hold for the pin, then wait for the PLL after a hardware reset.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      seq_state <= SRS_SEQ_RUN;
      seq_cnt   <= 11'd0;
      long_hw   <= 1'b0;
    end
    else
    begin
      unique case (seq_state)
        SRS_SEQ_IDLE:
        begin
          seq_cnt <= 11'd0;
          if (start_seq)
            seq_state <= SRS_SEQ_RUN;
        end
        SRS_SEQ_RUN:
        begin
          seq_cnt <= seq_cnt + 11'd1;
          if (seq_done)
          begin
            long_hw   <= !rst_pin_n;
            seq_state <= SRS_SEQ_HOLD;
          end
        end
        SRS_SEQ_HOLD:
        begin
          if (rst_pin_n)
            seq_state <= SRS_SEQ_LENGTHEN;
        end
        SRS_SEQ_LENGTHEN:
        begin
          if (osc_pll_stable_i || !(short_hw || long_hw))
            seq_state <= SRS_SEQ_IDLE;
        end
      endcase
    end
  end

  // Reset type bookkeeping, visible through the watchdog control image.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      soft_type <= 1'b0;
      short_hw  <= 1'b1;
      wdog_type <= 1'b0;
    end
    else if (start_seq)
    begin
      soft_type <= pulse_soft;
      wdog_type <= pulse_wdog ? 1'b1 : (hw_req ? 1'b0 : wdog_type);
      short_hw  <= hw_req;
    end
    else if (wdog_service_instr_i && seq_state == SRS_SEQ_IDLE)
      wdog_type <= 1'b0;
  end

  // Sampling follows the sequence, not the clock lengthening phase.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      cfg_latch_o   <= 1'b0;
      cfg_latched_o <= 8'h00;
    end
    else
    begin
      cfg_latch_o <= (seq_state == SRS_SEQ_HOLD) && rst_pin_n;
      if ((seq_state == SRS_SEQ_HOLD) && rst_pin_n)
        cfg_latched_o <= startup_cfg_i;
    end
  end

  // Reset outputs and pin-side drive.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      sys_reset_o       <= 1'b1;
      sys_reset_out_n_o <= 1'b0;
      ext_reset_oe_o    <= 1'b1;
      ext_reset_out_o   <= 1'b0;
      bus_pins_active_o <= 1'b0;
      gpio_output_en_o  <= 1'b0;
    end
    else
    begin
      sys_reset_o <= (seq_state != SRS_SEQ_IDLE) || start_seq;
      ext_reset_oe_o <= (seq_state == SRS_SEQ_RUN) || start_seq;
      ext_reset_out_o <= 1'b0;
      if (start_seq)
        sys_reset_out_n_o <= 1'b0;
      else if (end_init_instr_i && seq_state == SRS_SEQ_IDLE)
        sys_reset_out_n_o <= 1'b1;
      bus_pins_active_o <= (seq_state == SRS_SEQ_IDLE) && !start_seq;
      gpio_output_en_o  <= 1'b0;
    end
  end

  // Idle wakeup holds the first fetch without stretching reset.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      setup_active_o <= 1'b0;
    else
      setup_active_o <= idle_wakeup_i && !clk_dist_stable_i;
  end

  // Disable is honoured only until the first service or end-of-init.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || seq_state != SRS_SEQ_IDLE)
    begin
      dis_window <= 1'b1;
      wdog_off   <= 1'b0;
    end
    else
    begin
      if (wdog_service_instr_i || end_init_instr_i)
        dis_window <= 1'b0;
      if (wdog_disable_instr_i && dis_window)
        wdog_off <= 1'b1;
    end
  end

  assign wdog_run  = (seq_state == SRS_SEQ_IDLE);
  assign wdog_gate = wdog_disable_instr_i && dis_window;

  srs_wdog u_wdog (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .run_i     (wdog_run),
    .service_i (wdog_service_instr_i),
    .disable_i (wdog_gate),
    .overflow_o(wdog_ovf)
  );

  // Block soft reset register; unused bits read as zero.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || sys_reset_o)
      blk_rst <= `SRS_BLK_RST_RESET;
    else if (reg_wr_i && addr_hit(reg_addr_i))
      blk_rst <= reg_wdata_i & `SRS_BLK_RST_MASK;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      reg_rdata_o       <= 8'h00;
      hdlc_reset_o      <= 1'b0;
      tdm_reset_o       <= 1'b0;
      trx_reset_o       <= 1'b0;
      wdog_ctrl_reg_o   <= 4'h0;
      wdog_reset_flag_o <= 1'b0;
    end
    else
    begin
      reg_rdata_o <= (reg_rd_i && addr_hit(reg_addr_i)) ? blk_rst : 8'h00;
      hdlc_reset_o <= blk_rst[`SRS_BIT_HDLC];
      tdm_reset_o  <= blk_rst[`SRS_BIT_TDM];
      trx_reset_o  <= blk_rst[`SRS_BIT_TR];
      wdog_ctrl_reg_o   <= {wdog_off, short_hw, wdog_type, soft_type};
      wdog_reset_flag_o <= wdog_type;
    end
  end

  // DSP: reset while the system reset output is low, active on access.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      dsp_state    <= SRS_DSP_RESET;
      dsp_reset_o  <= 1'b1;
      dsp_active_o <= 1'b0;
    end
    else
    begin
      unique case (dsp_state)
        SRS_DSP_RESET:
          if (sys_reset_out_n_o)
            dsp_state <= SRS_DSP_WAIT;
        SRS_DSP_WAIT:
          if (!sys_reset_out_n_o)
            dsp_state <= SRS_DSP_RESET;
          else if (dsp_reg_access_i)
            dsp_state <= SRS_DSP_ACTIVE;
        SRS_DSP_ACTIVE:
          if (!sys_reset_out_n_o)
            dsp_state <= SRS_DSP_RESET;
        default:
          dsp_state <= SRS_DSP_RESET;
      endcase
      dsp_reset_o  <= !sys_reset_out_n_o;
      dsp_active_o <= (dsp_state == SRS_DSP_ACTIVE) && sys_reset_out_n_o;
    end
  end
endmodule : srs_sequencer

// file: test/srs_sequencer_assertions.sv
// Checker for the reset sequencer outputs.
`timescale 1ns/100ps
module srs_seq_chk (
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  input wire logic        ext_reset_in_n_i,
  input wire logic        soft_reset_instr_i,
  input wire logic        end_init_instr_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [7:0]  reg_wdata_i,
  input wire logic [7:0]  reg_rdata_o,
  input wire logic        sys_reset_o,
  input wire logic        sys_reset_out_n_o,
  input wire logic        cfg_latch_o,
  input wire logic        gpio_output_en_o,
  input wire logic        hdlc_reset_o,
  input wire logic        dsp_reset_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  int hi_cnt;
  int low_cnt;
  // Counters stand in for repetitions far too long to unroll.
  always_ff @(posedge sys_clk_i)
  begin
    hi_cnt  <= (rst_i || !sys_reset_o) ? 0 : hi_cnt + 1;
    low_cnt <= ext_reset_in_n_i ? 0 : low_cnt + 1;
  end
  a_out_low: assert property (sys_reset_o |-> !sys_reset_out_n_o)
    else $error("reset output released during reset");
  a_min_len: assert property ($fell(sys_reset_o) |-> hi_cnt >= 1024)
    else $error("reset shorter than minimum");
  a_pin_start: assert property (low_cnt >= 14 |-> sys_reset_o)
    else $error("held reset pin did not start sequence");
  a_soft_go: assert property (soft_reset_instr_i && !sys_reset_o
    |-> ##[1:2] sys_reset_o) else $error("soft reset not started");
  a_blk_wr: assert property (reg_wr_i && reg_addr_i == 16'he63f
    && !sys_reset_o ##1 !sys_reset_o
    |-> ##1 hdlc_reset_o == $past(reg_wdata_i[3], 2))
    else $error("block reset output wrong");
  a_rd_other: assert property (reg_rd_i && reg_addr_i != 16'he63f
    |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
  a_sys_reset_out_go: assert property (end_init_instr_i && !sys_reset_o
    |=> sys_reset_out_n_o) else $error("reset output not released");
  a_dsp_hold: assert property (!sys_reset_out_n_o [*2] |-> dsp_reset_o)
    else $error("processor left reset early");
  a_cfg_in: assert property (cfg_latch_o |-> sys_reset_o)
    else $error("config latched outside reset");
  a_gpio_in: assert property (!gpio_output_en_o)
    else $error("general pins driven");
  c_rel: cover property ($fell(sys_reset_o));
  c_out: cover property ($rose(sys_reset_out_n_o));
  c_soft: cover property (soft_reset_instr_i && !sys_reset_o);
endmodule : srs_seq_chk
bind srs_sequencer srs_seq_chk srs_seq_chk_i (.sys_clk_i, .rst_i,
  .ext_reset_in_n_i, .soft_reset_instr_i, .end_init_instr_i, .reg_addr_i,
  .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .sys_reset_o,
  .sys_reset_out_n_o, .cfg_latch_o, .gpio_output_en_o, .hdlc_reset_o,
  .dsp_reset_o);

// file: test/srs_ext_model.sv
// Model of the outside reset circuit and clock source.
`timescale 1ns/100ps
module srs_ext_model (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic        go_i,
  input  wire logic [11:0] len_i,
  input  wire logic        pll_slow_i,
  output logic             pin_n_o,
  output logic             pll_ok_o
);
  int left;
  int settle;
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      left <= 1036;
    else if (go_i)
      left <= len_i;
    else if (left > 0)
      left <= left - 1;
  end
  // A slow source keeps the clock unsettled well past the sequence end.
  always_ff @(posedge sys_clk_i)
  begin
    if (go_i && pll_slow_i)
      settle <= 1200;
    else if (settle > 0)
      settle <= settle - 1;
  end
  assign pin_n_o  = (left == 0);
  assign pll_ok_o = (settle == 0);
endmodule : srs_ext_model

// file: test/srs_sequencer_tb_top.sv
// Self-checking bench for the reset sequencer.
`timescale 1ns/100ps
`define CHK(g, e) \
  begin \
    checks++; \
    if ((g) !== (e)) \
    begin \
      miscompares++; \
      $display("MISMATCH %0t got %h want %h", $time, g, e); \
    end \
  end
module srs_sequencer_tb_top;
  logic sys_clk_i = 0, rst_i = 1, soft_reset_instr_i = 0;
  logic end_init_instr_i = 0, dsp_reg_access_i = 0;
  logic wdog_disable_instr_i = 0, wdog_service_instr_i = 0;
  logic ext_bus_busy_i = 0, bootstrap_mode_i = 0;
  logic idle_wakeup_i = 0, clk_dist_stable_i = 1;
  logic reg_wr_i = 0, reg_rd_i = 0, go = 0, slow = 0;
  logic [15:0] reg_addr_i = 16'h0000;
  logic [7:0]  reg_wdata_i = 8'h00, startup_cfg_i = 8'h00;
  logic        ext_reset_in_n_i, osc_pll_stable_i;
  logic [7:0]  reg_rdata_o, cfg_latched_o, d, e;
  logic [3:0]  wdog_ctrl_reg_o;
  logic        sys_reset_o, sys_reset_out_n_o, setup_active_o;
  logic        bus_pins_active_o, gpio_output_en_o, hdlc_reset_o;
  logic        tdm_reset_o, trx_reset_o, dsp_reset_o, dsp_active_o;
  logic        wdog_reset_flag_o;
  logic        ext_reset_oe_o, ext_reset_out_o;
  logic [2:0]  s;
  logic [7:0]  ob [8];
  logic [7:0]  eq [$];
  logic [2:0]  sq [$];
  logic [31:0] seed = 32'h20423222;
  int          checks = 0, miscompares = 0;
  always #20 sys_clk_i = ~sys_clk_i;
  srs_ext_model srs_ext_model_i (.sys_clk_i, .rst_i, .go_i(go),
    .len_i(12'h014), .pll_slow_i(slow), .pin_n_o(ext_reset_in_n_i),
    .pll_ok_o(osc_pll_stable_i));
  srs_sequencer srs_sequencer_i (.sys_clk_i, .rst_i, .ext_reset_in_n_i,
    .soft_reset_instr_i, .end_init_instr_i, .wdog_disable_instr_i,
    .wdog_service_instr_i, .ext_bus_busy_i, .bootstrap_mode_i,
    .osc_pll_stable_i, .idle_wakeup_i, .clk_dist_stable_i, .startup_cfg_i,
    .dsp_reg_access_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
    .reg_rdata_o, .sys_reset_o, .sys_reset_out_n_o, .ext_reset_oe_o,
    .ext_reset_out_o, .setup_active_o, .cfg_latch_o(), .cfg_latched_o,
    .bus_pins_active_o, .gpio_output_en_o, .hdlc_reset_o, .tdm_reset_o,
    .trx_reset_o, .dsp_reset_o, .dsp_active_o, .wdog_ctrl_reg_o,
    .wdog_reset_flag_o);
  assign ob[0] = reg_rdata_o;
  assign ob[1] = {5'h00, hdlc_reset_o, tdm_reset_o, trx_reset_o};
  assign ob[2] = {6'h00, sys_reset_o, sys_reset_out_n_o};
  assign ob[3] = {6'h00, dsp_reset_o, dsp_active_o};
  assign ob[4] = cfg_latched_o;
  assign ob[5] = {7'h00, wdog_reset_flag_o};
  assign ob[6] = {5'h00, setup_active_o, bus_pins_active_o,
                  gpio_output_en_o};
  // Pin drive and the whole control image share one slot.
  assign ob[7] = {2'h0, ext_reset_out_o, ext_reset_oe_o, wdog_ctrl_reg_o};
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task cyc(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask : cyc
  task note(input logic [2:0] sel, input logic [7:0] ev);
    sq.push_back(sel);
    eq.push_back(ev);
  endtask : note
  task wr(input logic [15:0] a, input logic [7:0] v);
    reg_addr_i = a;
    reg_wdata_i = v;
    reg_wr_i = 1;
    cyc(1);
    reg_wr_i = 0;
  endtask : wr
  task rd(input logic [15:0] a, input logic [7:0] v);
    reg_addr_i = a;
    reg_rd_i = 1;
    cyc(1);
    reg_rd_i = 0;
    note(0, v);
  endtask : rd
  task give_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict
  // Values read here were launched by the previous edge, so no race.
  always @(posedge sys_clk_i)
    while (sq.size() > 0)
    begin
      s = sq.pop_front();
      e = eq.pop_front();
      `CHK(ob[s], e)
    end
  initial
  begin
    #(40 * 12000);
    miscompares++;
    give_verdict();
  end
  initial
  begin
    startup_cfg_i = 8'(rnd());
    cyc(6);
    rst_i = 0;
    cyc(1000);
    note(2, 8'h02);
    wr(16'he63f, 8'h0e);
    cyc(100);
    note(2, 8'h00);
    note(4, startup_cfg_i);
    note(3, 8'h02);
    note(6, 8'h02);
    rd(16'he63f, 8'h00);
    repeat (4)
    begin
      d = 8'(rnd());
      wr(16'he63f, d);
      rd(16'he63f, d & 8'h0e);
      note(1, {5'h00, d[3:1]});
    end
    cyc(1);
    rd(16'h1234, 8'h00);
    end_init_instr_i = 1;
    cyc(1);
    end_init_instr_i = 0;
    cyc(2);
    note(2, 8'h01);
    note(3, 8'h00);
    dsp_reg_access_i = 1;
    cyc(1);
    dsp_reg_access_i = 0;
    cyc(2);
    note(3, 8'h01);
    // End-of-init has closed the window, so disable must do nothing.
    wdog_disable_instr_i = 1;
    cyc(1);
    wdog_disable_instr_i = 0;
    cyc(2);
    note(7, 8'h04);
    clk_dist_stable_i = 0;
    idle_wakeup_i = 1;
    cyc(3);
    note(6, 8'h06);
    note(2, 8'h01);
    clk_dist_stable_i = 1;
    cyc(3);
    note(6, 8'h02);
    idle_wakeup_i = 0;
    wr(16'he63f, 8'h0e);
    startup_cfg_i = 8'(rnd());
    soft_reset_instr_i = 1;
    cyc(1);
    soft_reset_instr_i = 0;
    cyc(4);
    note(2, 8'h02);
    note(7, 8'h11);
    note(1, 8'h00);
    cyc(1010);
    note(2, 8'h02);
    cyc(100);
    note(2, 8'h00);
    note(4, startup_cfg_i);
    wdog_disable_instr_i = 1;
    cyc(1);
    wdog_disable_instr_i = 0;
    cyc(2);
    note(7, 8'h09);
    slow = 1;
    go = 1;
    cyc(1);
    go = 0;
    cyc(20);
    note(2, 8'h02);
    note(5, 8'h00);
    cyc(1100);
    note(2, 8'h02);
    note(7, 8'h04);
    cyc(200);
    note(2, 8'h00);
    cyc(2);
    give_verdict();
  end
endmodule : srs_sequencer_tb_top
